// ### hdl/csl_config_regs.sv
// output six/seven source select and loop zero analog control registers
// Contract
// - output six takes its source from a three-bit code: loop zero, loop one, output two, output three, reference zero, reference one, reserved, crystal.
// - output seven uses the same code and resets to reference one.
// - software writes zero to reserved bits, whose read value is undefined.
// - the pump current field steps 110 uA per code from 110 uA to 880 uA, reset code 100.
// - the series resistor field picks 330, 640, 1200 or 1790 ohms, reset code 01.
// - the parallel capacitor field picks 40, 80, 140 or 200 pF, reset code 01.
// - the lock count bit picks 1 ppm when clear and 16 ppm when set, reset set.
// - the lock override bit picks automatic lock when clear and manual when set, reset clear.
// - in manual lock the oscillator bit picks the second oscillator when clear, the first when set, reset set.
// - a five-bit field holds the manual lock code of the second oscillator, reset zero.
// - the synth-only bit makes loop zero use the crystal alone when set, tracking references when clear.
module csl_config_regs (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [csl_pkg::ADDR_W-1:0] regAddr,
   input wire logic [csl_pkg::DATA_W-1:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [csl_pkg::DATA_W-1:0] regRdData_q,
   output logic regRdValid_q,
   output logic [2:0] out6SourceSel_q,
   output logic [2:0] out7SourceSel_q,
   output logic [csl_pkg::SRC_N-1:0] out6SourceOneHot_q,
   output logic [csl_pkg::SRC_N-1:0] out7SourceOneHot_q,
   output logic [2:0] loop0PumpCurrent_q,
   output logic [1:0] loop0SeriesResistor_q,
   output logic [1:0] loop0ParallelCapacitor_q,
   output logic loop0SecondPole_q,
   output logic loop0LockCount_q,
   output logic loop0LockOverride_q,
   output logic loop0OscChoice_q,
   output logic [4:0] loop0FirstOscCode_q,
   output logic [4:0] loop0SecondOscCode_q,
   output logic loop0SynthOnly_q,
   output logic [9:0] loop0PumpUa_q,
   output logic [10:0] loop0SeriesOhm_q,
   output logic [7:0] loop0ParallelPf_q,
   output logic [4:0] loop0LockPpm_q,
   output logic loop0ManualActive_q,
   output logic loop0ManualFirstOsc_q,
   output logic [4:0] loop0ManualCode_q
);
   logic rstMeta_q;
   logic rstSync_b;

   // reset release synchroniser
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rstMeta_q <= 1'b0;
         rstSync_b <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstSync_b <= rstMeta_q;
      end
   end

   // write decode
   logic wrSrc;
   logic wrFilter;
   logic wrLock;
   logic wrCode1;
   logic wrCode2;

   always_comb begin
      wrSrc = regWr && (regAddr == csl_pkg::ADDR_SRC_SEL);
      wrFilter = regWr && (regAddr == csl_pkg::ADDR_FILTER);
      wrLock = regWr && (regAddr == csl_pkg::ADDR_LOCK);
      wrCode1 = regWr && (regAddr == csl_pkg::ADDR_CODE1);
      wrCode2 = regWr && (regAddr == csl_pkg::ADDR_CODE2);
   end

   // field next values
   logic [2:0] out6SourceSel_d;
   logic [2:0] out7SourceSel_d;
   logic [2:0] loop0PumpCurrent_d;
   logic [1:0] loop0SeriesResistor_d;
   logic [1:0] loop0ParallelCapacitor_d;
   logic loop0SecondPole_d;
   logic loop0LockCount_d;
   logic loop0LockOverride_d;
   logic loop0OscChoice_d;
   logic [4:0] loop0FirstOscCode_d;
   logic [4:0] loop0SecondOscCode_d;
   logic loop0SynthOnly_d;

   always_comb begin
      out6SourceSel_d = out6SourceSel_q;
      out7SourceSel_d = out7SourceSel_q;
      loop0PumpCurrent_d = loop0PumpCurrent_q;
      loop0SeriesResistor_d = loop0SeriesResistor_q;
      loop0ParallelCapacitor_d = loop0ParallelCapacitor_q;
      loop0SecondPole_d = loop0SecondPole_q;
      loop0LockCount_d = loop0LockCount_q;
      loop0LockOverride_d = loop0LockOverride_q;
      loop0OscChoice_d = loop0OscChoice_q;
      loop0FirstOscCode_d = loop0FirstOscCode_q;
      loop0SecondOscCode_d = loop0SecondOscCode_q;
      loop0SynthOnly_d = loop0SynthOnly_q;
      if (wrSrc) begin
         out6SourceSel_d = regWrData[csl_pkg::OUT6_LSB +: csl_pkg::SEL_W];
         out7SourceSel_d = regWrData[csl_pkg::OUT7_LSB +: csl_pkg::SEL_W];
      end
      if (wrFilter) begin
         loop0PumpCurrent_d = regWrData[csl_pkg::PUMP_LSB +: csl_pkg::PUMP_W];
         loop0SeriesResistor_d = regWrData[csl_pkg::RES_LSB +: csl_pkg::RES_W];
         loop0ParallelCapacitor_d = regWrData[csl_pkg::CAP_LSB +: csl_pkg::CAP_W];
         loop0SecondPole_d = regWrData[csl_pkg::POLE_BIT];
      end
      if (wrLock) begin
         loop0SynthOnly_d = regWrData[csl_pkg::SYNTH_BIT];
         loop0LockCount_d = regWrData[csl_pkg::COUNT_BIT];
         loop0LockOverride_d = regWrData[csl_pkg::OVERRIDE_BIT];
      end
      if (wrCode1) begin
         loop0OscChoice_d = regWrData[csl_pkg::CHOICE_BIT];
         loop0FirstOscCode_d = regWrData[csl_pkg::CODE_LSB +: csl_pkg::CODE_W];
      end
      if (wrCode2) begin
         loop0SecondOscCode_d = regWrData[csl_pkg::CODE_LSB +: csl_pkg::CODE_W];
      end
   end

   always_ff @(posedge mclk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         out6SourceSel_q <= csl_pkg::OUT6_RST;
         out7SourceSel_q <= csl_pkg::OUT7_RST;
         loop0PumpCurrent_q <= csl_pkg::PUMP_RST;
         loop0SeriesResistor_q <= csl_pkg::RES_RST;
         loop0ParallelCapacitor_q <= csl_pkg::CAP_RST;
         loop0SecondPole_q <= csl_pkg::POLE_RST;
         loop0LockCount_q <= csl_pkg::COUNT_RST;
         loop0LockOverride_q <= csl_pkg::OVERRIDE_RST;
         loop0OscChoice_q <= csl_pkg::CHOICE_RST;
         loop0FirstOscCode_q <= csl_pkg::CODE1_RST;
         loop0SecondOscCode_q <= csl_pkg::CODE2_RST;
         loop0SynthOnly_q <= csl_pkg::SYNTH_RST;
      end else begin
         out6SourceSel_q <= out6SourceSel_d;
         out7SourceSel_q <= out7SourceSel_d;
         loop0PumpCurrent_q <= loop0PumpCurrent_d;
         loop0SeriesResistor_q <= loop0SeriesResistor_d;
         loop0ParallelCapacitor_q <= loop0ParallelCapacitor_d;
         loop0SecondPole_q <= loop0SecondPole_d;
         loop0LockCount_q <= loop0LockCount_d;
         loop0LockOverride_q <= loop0LockOverride_d;
         loop0OscChoice_q <= loop0OscChoice_d;
         loop0FirstOscCode_q <= loop0FirstOscCode_d;
         loop0SecondOscCode_q <= loop0SecondOscCode_d;
         loop0SynthOnly_q <= loop0SynthOnly_d;
      end
   end

   // read mux, reserved bits read zero
   logic [csl_pkg::DATA_W-1:0] regRdData_d;
   logic regRdValid_d;

   always_comb begin
      regRdData_d = regRdData_q;
      regRdValid_d = regRd;
      if (regRd) begin
         regRdData_d = '0;
         unique case (regAddr)
            csl_pkg::ADDR_SRC_SEL: begin
               regRdData_d[csl_pkg::OUT6_LSB +: csl_pkg::SEL_W] = out6SourceSel_q;
               regRdData_d[csl_pkg::OUT7_LSB +: csl_pkg::SEL_W] = out7SourceSel_q;
            end
            csl_pkg::ADDR_FILTER: begin
               regRdData_d[csl_pkg::PUMP_LSB +: csl_pkg::PUMP_W] = loop0PumpCurrent_q;
               regRdData_d[csl_pkg::RES_LSB +: csl_pkg::RES_W] = loop0SeriesResistor_q;
               regRdData_d[csl_pkg::CAP_LSB +: csl_pkg::CAP_W] = loop0ParallelCapacitor_q;
               regRdData_d[csl_pkg::POLE_BIT] = loop0SecondPole_q;
            end
            csl_pkg::ADDR_LOCK: begin
               regRdData_d[csl_pkg::SYNTH_BIT] = loop0SynthOnly_q;
               regRdData_d[csl_pkg::COUNT_BIT] = loop0LockCount_q;
               regRdData_d[csl_pkg::OVERRIDE_BIT] = loop0LockOverride_q;
            end
            csl_pkg::ADDR_CODE1: begin
               regRdData_d[csl_pkg::CHOICE_BIT] = loop0OscChoice_q;
               regRdData_d[csl_pkg::CODE_LSB +: csl_pkg::CODE_W] = loop0FirstOscCode_q;
            end
            csl_pkg::ADDR_CODE2: begin
               regRdData_d[csl_pkg::CODE_LSB +: csl_pkg::CODE_W] = loop0SecondOscCode_q;
            end
            default: begin
               regRdData_d = '0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         regRdData_q <= '0;
         regRdValid_q <= 1'b0;
      end else begin
         regRdData_q <= regRdData_d;
         regRdValid_q <= regRdValid_d;
      end
   end

   // source decoders for outputs six and seven
   csl_src_decode u_out6Decode (
      .mclk(mclk),
      .rstSync_b(rstSync_b),
      .sel(out6SourceSel_q),
      .srcOneHot_q(out6SourceOneHot_q)
   );

   csl_src_decode u_out7Decode (
      .mclk(mclk),
      .rstSync_b(rstSync_b),
      .sel(out7SourceSel_q),
      .srcOneHot_q(out7SourceOneHot_q)
   );

   // analog settings in physical units and manual lock view
   logic [9:0] loop0PumpUa_d;
   logic [10:0] loop0SeriesOhm_d;
   logic [7:0] loop0ParallelPf_d;
   logic [4:0] loop0LockPpm_d;
   logic loop0ManualActive_d;
   logic loop0ManualFirstOsc_d;
   logic [4:0] loop0ManualCode_d;

   always_comb begin
      loop0PumpUa_d = 10'((10'(loop0PumpCurrent_q) + 10'h001) * csl_pkg::PUMP_STEP_UA);
      unique case (loop0SeriesResistor_q)
         2'h0: loop0SeriesOhm_d = csl_pkg::RES_OHM_0;
         2'h1: loop0SeriesOhm_d = csl_pkg::RES_OHM_1;
         2'h2: loop0SeriesOhm_d = csl_pkg::RES_OHM_2;
         2'h3: loop0SeriesOhm_d = csl_pkg::RES_OHM_3;
      endcase
      unique case (loop0ParallelCapacitor_q)
         2'h0: loop0ParallelPf_d = csl_pkg::CAP_PF_0;
         2'h1: loop0ParallelPf_d = csl_pkg::CAP_PF_1;
         2'h2: loop0ParallelPf_d = csl_pkg::CAP_PF_2;
         2'h3: loop0ParallelPf_d = csl_pkg::CAP_PF_3;
      endcase
      loop0LockPpm_d = loop0LockCount_q ? csl_pkg::PPM_COARSE : csl_pkg::PPM_FINE;
      loop0ManualActive_d = loop0LockOverride_q;
      loop0ManualFirstOsc_d = loop0LockOverride_q && loop0OscChoice_q;
      loop0ManualCode_d = '0;
      if (loop0LockOverride_q) begin
         loop0ManualCode_d = loop0OscChoice_q ? loop0FirstOscCode_q : loop0SecondOscCode_q;
      end
   end

   always_ff @(posedge mclk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         loop0PumpUa_q <= '0;
         loop0SeriesOhm_q <= '0;
         loop0ParallelPf_q <= '0;
         loop0LockPpm_q <= '0;
         loop0ManualActive_q <= 1'b0;
         loop0ManualFirstOsc_q <= 1'b0;
         loop0ManualCode_q <= '0;
      end else begin
         loop0PumpUa_q <= loop0PumpUa_d;
         loop0SeriesOhm_q <= loop0SeriesOhm_d;
         loop0ParallelPf_q <= loop0ParallelPf_d;
         loop0LockPpm_q <= loop0LockPpm_d;
         loop0ManualActive_q <= loop0ManualActive_d;
         loop0ManualFirstOsc_q <= loop0ManualFirstOsc_d;
         loop0ManualCode_q <= loop0ManualCode_d;
      end
   end

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstSync_b);

   sequence lockWrite_s;
      wrLock ##1 regRd && (regAddr == csl_pkg::ADDR_LOCK);
   endsequence

   sequence srcWrite_s;
      wrSrc;
   endsequence

   out6_route_a: assert property (srcWrite_s |-> ##2
      out6SourceOneHot_q ==
         (($past(regWrData[csl_pkg::OUT6_LSB +: csl_pkg::SEL_W], 2) == 3'h6) ? 8'h00 :
         8'(1 << $past(regWrData[csl_pkg::OUT6_LSB +: csl_pkg::SEL_W], 2))))
      else $error("output six source decode wrong");

   out7_reset_a: assert property ($rose(rstSync_b) |-> out7SourceSel_q == 3'h5)
      else $error("output seven selector not reset to reference one");

   pump_step_a: assert property ($past(rstSync_b) |-> loop0PumpUa_q ==
      10'((10'($past(loop0PumpCurrent_q)) + 10'h001) * 10'h06E))
      else $error("pump current step wrong");

   resistor_min_a: assert property ($past(loop0SeriesResistor_q) == 2'h0 |->
      loop0SeriesOhm_q == 11'h14A)
      else $error("series resistor low code wrong");

   capacitor_top_a: assert property ($past(loop0ParallelCapacitor_q) == 2'h3 |->
      loop0ParallelPf_q == 8'hC8)
      else $error("parallel capacitor top code wrong");

   lock_ppm_a: assert property ($past(rstSync_b) |-> loop0LockPpm_q ==
      ($past(loop0LockCount_q) ? 5'h10 : 5'h01))
      else $error("lock accuracy wrong");

   auto_code_a: assert property (!loop0LockOverride_q |=>
      loop0ManualCode_q == 5'h00 && !loop0ManualActive_q)
      else $error("manual code leaks in automatic mode");

   osc_pick_a: assert property (loop0LockOverride_q && !loop0OscChoice_q |=>
      !loop0ManualFirstOsc_q && loop0ManualCode_q == $past(loop0SecondOscCode_q))
      else $error("second oscillator not picked");

   code1_write_a: assert property (wrCode1 |=>
      loop0FirstOscCode_q == $past(regWrData[4:0]))
      else $error("first oscillator code not stored");

   lock_readback_a: assert property (lockWrite_s |=>
      regRdValid_q && regRdData_q == ($past(regWrData, 2) & 8'h0B))
      else $error("lock setup readback wrong");
endmodule

// ### hdl/csl_pkg.sv
// constants for the output source and loop zero configuration registers
package csl_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;

   // register byte addresses
   localparam logic [15:0] ADDR_SRC_SEL = 16'h00AA;
   localparam logic [15:0] ADDR_FILTER = 16'h00AC;
   localparam logic [15:0] ADDR_LOCK = 16'h00AD;
   localparam logic [15:0] ADDR_CODE1 = 16'h00AE;
   localparam logic [15:0] ADDR_CODE2 = 16'h00AF;

   // source select register fields
   localparam int OUT6_LSB = 0;
   localparam int OUT7_LSB = 3;
   localparam int SEL_W = 3;

   // filter setup register fields
   localparam int PUMP_LSB = 5;
   localparam int PUMP_W = 3;
   localparam int RES_LSB = 3;
   localparam int RES_W = 2;
   localparam int CAP_LSB = 1;
   localparam int CAP_W = 2;
   localparam int POLE_BIT = 0;

   // lock setup register fields
   localparam int SYNTH_BIT = 3;
   localparam int COUNT_BIT = 1;
   localparam int OVERRIDE_BIT = 0;

   // lock code register fields
   localparam int CHOICE_BIT = 5;
   localparam int CODE_LSB = 0;
   localparam int CODE_W = 5;

   // reset values
   localparam logic [2:0] OUT6_RST = 3'h0;
   localparam logic [2:0] OUT7_RST = 3'h5;
   localparam logic [2:0] PUMP_RST = 3'h4;
   localparam logic [1:0] RES_RST = 2'h1;
   localparam logic [1:0] CAP_RST = 2'h1;
   localparam logic POLE_RST = 1'b1;
   localparam logic COUNT_RST = 1'b1;
   localparam logic OVERRIDE_RST = 1'b0;
   localparam logic CHOICE_RST = 1'b1;
   localparam logic [4:0] CODE1_RST = 5'h0B;
   localparam logic [4:0] CODE2_RST = 5'h00;
   localparam logic SYNTH_RST = 1'b0;

   // output source codes
   typedef enum logic [2:0] {
      SRC_LOOP0 = 3'h0,
      SRC_LOOP1 = 3'h1,
      SRC_OUT2 = 3'h2,
      SRC_OUT3 = 3'h3,
      SRC_REF0 = 3'h4,
      SRC_REF1 = 3'h5,
      SRC_RSVD = 3'h6,
      SRC_XTAL = 3'h7
   } csl_src_t;
   localparam int SRC_N = 8;

   // analog settings in physical units
   localparam logic [9:0] PUMP_STEP_UA = 10'h06E;
   localparam logic [10:0] RES_OHM_0 = 11'h14A;
   localparam logic [10:0] RES_OHM_1 = 11'h280;
   localparam logic [10:0] RES_OHM_2 = 11'h4B0;
   localparam logic [10:0] RES_OHM_3 = 11'h6FE;
   localparam logic [7:0] CAP_PF_0 = 8'h28;
   localparam logic [7:0] CAP_PF_1 = 8'h50;
   localparam logic [7:0] CAP_PF_2 = 8'h8C;
   localparam logic [7:0] CAP_PF_3 = 8'hC8;
   localparam logic [4:0] PPM_FINE = 5'h01;
   localparam logic [4:0] PPM_COARSE = 5'h10;
endpackage

// ### hdl/csl_src_decode.sv
// registered one-hot decode of a three-bit output source selector, all zero for the reserved code
module csl_src_decode (
   input wire logic mclk,
   input wire logic rstSync_b,
   input wire logic [2:0] sel,
   output logic [csl_pkg::SRC_N-1:0] srcOneHot_q
);
   logic [csl_pkg::SRC_N-1:0] srcOneHot_d;

   always_comb begin
      srcOneHot_d = '0;
      if (sel != csl_pkg::SRC_RSVD) begin
         srcOneHot_d[sel] = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         srcOneHot_q <= '0;
      end else begin
         srcOneHot_q <= srcOneHot_d;
      end
   end
endmodule

// ### testbench/csl_config_regs_bench.sv
// self-checking bench for the output source and loop zero configuration registers
module csl_config_regs_bench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int TIMEOUT_CYC = 6000;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic [15:0] regAddr = 16'h0000;
   logic [7:0] regWrData = 8'h00;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [7:0] regRdData_q, out6SourceOneHot_q, out7SourceOneHot_q, loop0ParallelPf_q;
   logic regRdValid_q, loop0SecondPole_q, loop0LockCount_q, loop0LockOverride_q;
   logic loop0OscChoice_q, loop0SynthOnly_q, loop0ManualActive_q, loop0ManualFirstOsc_q;
   logic [2:0] out6SourceSel_q, out7SourceSel_q, loop0PumpCurrent_q;
   logic [1:0] loop0SeriesResistor_q, loop0ParallelCapacitor_q;
   logic [4:0] loop0FirstOscCode_q, loop0SecondOscCode_q, loop0LockPpm_q, loop0ManualCode_q;
   logic [9:0] loop0PumpUa_q;
   logic [10:0] loop0SeriesOhm_q;
   logic [10:0] ohmTab [4] = '{11'h14A, 11'h280, 11'h4B0, 11'h6FE};
   logic [7:0] pfTab [4] = '{8'h28, 8'h50, 8'h8C, 8'hC8};
   int errors = 0;
   int n_checks = 0;
   int cycles = 0;

   csl_config_regs uut (
      .mclk, .rst_b, .regAddr, .regWrData, .regWr, .regRd, .regRdData_q, .regRdValid_q,
      .out6SourceSel_q, .out7SourceSel_q, .out6SourceOneHot_q, .out7SourceOneHot_q,
      .loop0PumpCurrent_q, .loop0SeriesResistor_q, .loop0ParallelCapacitor_q,
      .loop0SecondPole_q, .loop0LockCount_q, .loop0LockOverride_q, .loop0OscChoice_q,
      .loop0FirstOscCode_q, .loop0SecondOscCode_q, .loop0SynthOnly_q, .loop0PumpUa_q,
      .loop0SeriesOhm_q, .loop0ParallelPf_q, .loop0LockPpm_q, .loop0ManualActive_q,
      .loop0ManualFirstOsc_q, .loop0ManualCode_q
   );

   always #20 mclk = ~mclk;

   always @(posedge mclk) begin
      cycles++;
      if (cycles == TIMEOUT_CYC) begin
         errors++;
         results();
      end
   end

   task automatic results();
      if (errors == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic do_reset();
      rst_b = 1'b0;
      repeat (8) @(posedge mclk);
      #1;
      rst_b = 1'b1;
      repeat (3) @(posedge mclk);
      #1;
   endtask

   // one write, then one idle cycle so derived outputs settle
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      regAddr = a;
      regWrData = d;
      regWr = 1'b1;
      @(posedge mclk);
      #1;
      regWr = 1'b0;
      @(posedge mclk);
      #1;
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      regAddr = a;
      regRd = 1'b1;
      @(posedge mclk);
      #1;
      regRd = 1'b0;
      check("read valid", {15'h0000, regRdValid_q}, 16'h0001);
      check("read data", {8'h00, regRdData_q}, {8'h00, exp});
      @(posedge mclk);
      #1;
      check("valid drop", {15'h0000, regRdValid_q}, 16'h0000);
   endtask

   task automatic t_defaults();
      rd(csl_pkg::ADDR_SRC_SEL, 8'h28);
      rd(csl_pkg::ADDR_FILTER, 8'h8B);
      rd(csl_pkg::ADDR_LOCK, 8'h02);
      rd(csl_pkg::ADDR_CODE1, 8'h2B);
      rd(csl_pkg::ADDR_CODE2, 8'h00);
      check("out7 sel", {13'h0000, out7SourceSel_q}, 16'h0005);
      check("out6 hot", {8'h00, out6SourceOneHot_q}, 16'h0001);
      check("pump ua", {6'h00, loop0PumpUa_q}, 16'h0226);
      check("ohm", {5'h00, loop0SeriesOhm_q}, 16'h0280);
      check("pf", {8'h00, loop0ParallelPf_q}, 16'h0050);
      check("ppm", {11'h000, loop0LockPpm_q}, 16'h0010);
      check("manual", {15'h0000, loop0ManualActive_q}, 16'h0000);
      check("first code", {11'h000, loop0FirstOscCode_q}, 16'h000B);
   endtask

   task automatic t_source_sel();
      logic [2:0] s6;
      logic [2:0] s7;
      for (int i = 0; i < 8; i++) begin
         s6 = 3'(i);
         s7 = 3'(7 - i);
         wr(csl_pkg::ADDR_SRC_SEL, {2'b00, s7, s6});
         check("out6 sel", {13'h0000, out6SourceSel_q}, {13'h0000, s6});
         check("out7 sel", {13'h0000, out7SourceSel_q}, {13'h0000, s7});
         check("out6 hot", {8'h00, out6SourceOneHot_q},
               (s6 == 3'h6) ? 16'h0000 : 16'h0001 << s6);
         check("out7 hot", {8'h00, out7SourceOneHot_q},
               (s7 == 3'h6) ? 16'h0000 : 16'h0001 << s7);
         rd(csl_pkg::ADDR_SRC_SEL, {2'b00, s7, s6});
      end
   endtask

   task automatic t_filter();
      logic [2:0] c;
      for (int i = 0; i < 8; i++) begin
         c = 3'(i);
         wr(csl_pkg::ADDR_FILTER, {c, c[1:0], ~c[1:0], c[0]});
         check("pump", {13'h0000, loop0PumpCurrent_q}, {13'h0000, c});
         check("pump ua", {6'h00, loop0PumpUa_q}, 16'((i + 1) * 16'h006E));
         check("res", {14'h0000, loop0SeriesResistor_q}, {14'h0000, c[1:0]});
         check("cap", {14'h0000, loop0ParallelCapacitor_q}, {14'h0000, ~c[1:0]});
         check("ohm", {5'h00, loop0SeriesOhm_q}, {5'h00, ohmTab[c[1:0]]});
         check("pf", {8'h00, loop0ParallelPf_q}, {8'h00, pfTab[~c[1:0]]});
         check("pole", {15'h0000, loop0SecondPole_q}, {15'h0000, c[0]});
         rd(csl_pkg::ADDR_FILTER, {c, c[1:0], ~c[1:0], c[0]});
      end
   endtask

   task automatic t_lock();
      logic [2:0] b;
      for (int i = 0; i < 8; i++) begin
         b = 3'(i);
         wr(csl_pkg::ADDR_LOCK, {4'h0, b[2], 1'b0, b[1:0]});
         check("synth", {15'h0000, loop0SynthOnly_q}, {15'h0000, b[2]});
         check("count", {15'h0000, loop0LockCount_q}, {15'h0000, b[1]});
         check("ppm", {11'h000, loop0LockPpm_q}, b[1] ? 16'h0010 : 16'h0001);
         check("override", {15'h0000, loop0LockOverride_q}, {15'h0000, b[0]});
         check("manual", {15'h0000, loop0ManualActive_q}, {15'h0000, b[0]});
      end
   endtask

   task automatic t_manual();
      logic [4:0] c1;
      logic [4:0] c2;
      logic ov;
      logic ch;
      for (int i = 0; i < 4; i++) begin
         c1 = 5'(5'h1F - i);
         c2 = 5'(5'h10 + i);
         ov = i[1];
         ch = i[0];
         wr(csl_pkg::ADDR_CODE1, {2'b00, ch, c1});
         wr(csl_pkg::ADDR_CODE2, {3'b000, c2});
         wr(csl_pkg::ADDR_LOCK, {7'h00, ov});
         check("choice", {15'h0000, loop0OscChoice_q}, {15'h0000, ch});
         check("code2", {11'h000, loop0SecondOscCode_q}, {11'h000, c2});
         check("first osc", {15'h0000, loop0ManualFirstOsc_q}, {15'h0000, ov & ch});
         check("man code", {11'h000, loop0ManualCode_q},
               {11'h000, ov ? (ch ? c1 : c2) : 5'h00});
         rd(csl_pkg::ADDR_CODE1, {2'b00, ch, c1});
      end
   endtask

   task automatic t_reserved();
      wr(csl_pkg::ADDR_LOCK, 8'h0B);
      rd(csl_pkg::ADDR_LOCK, 8'h0B);
      wr(16'h00AB, 8'hFF);
      rd(16'h00AB, 8'h00);
      rd(csl_pkg::ADDR_CODE2, 8'h13);
      regAddr = csl_pkg::ADDR_CODE2;
      regWrData = 8'h05;
      regWr = 1'b1;
      regRd = 1'b1;
      @(posedge mclk);
      #1;
      regWr = 1'b0;
      regRd = 1'b0;
      check("old on collide", {8'h00, regRdData_q}, 16'h0013);
      @(posedge mclk);
      #1;
      rd(csl_pkg::ADDR_CODE2, 8'h05);
   endtask

   task automatic t_wr_then_rd();
      regAddr = csl_pkg::ADDR_LOCK;
      regWrData = 8'h09;
      regWr = 1'b1;
      @(posedge mclk);
      #1;
      regWr = 1'b0;
      regRd = 1'b1;
      @(posedge mclk);
      #1;
      regRd = 1'b0;
      check("wr then rd", {8'h00, regRdData_q}, 16'h0009);
      check("wr then rd valid", {15'h0000, regRdValid_q}, 16'h0001);
   endtask

   initial begin
      do_reset();
      t_defaults();
      t_source_sel();
      t_filter();
      t_lock();
      t_manual();
      t_reserved();
      t_wr_then_rd();
      do_reset();
      t_defaults();
      results();
   end
endmodule
